// file: event_router.v
// Event router: channel generator muxes, synchronizers, consumer muxes, port outputs
`timescale 1ns/1ps
`include "event_router_regs.vh"
module event_router (
    input wire CORE_CLK,
    input wire SYS_RST,
    input wire CHAN_SEL_WR,
    input wire [`CHAN_ADDR_W-1:0] CHAN_SEL_ADDR,
    input wire [`GEN_SEL_W-1:0] CHAN_SEL_DATA,
    input wire USER_SEL_WR,
    input wire [`USER_ADDR_W-1:0] USER_SEL_ADDR,
    input wire [`USER_SEL_W-1:0] USER_SEL_DATA,
    input wire RTC_PRESCALED_TICK,
    input wire [`NUM_LUTS-1:0] LOGIC_TABLE_OUTPUT,
    input wire ANALOG_COMPARATOR,
    input wire [`NUM_PINS-1:0] PORT_PIN_LEVEL,
    input wire [`NUM_SYNC_PULSES-1:0] SYNC_PULSE_EVENT,
    input wire SERIAL_BAUD_CLOCK_EVENT,
    input wire SPI_HOST_CLOCK_EVENT,
    output wire [`NUM_CHANNELS-1:0] CHANNEL_ASYNC,
    output wire [`NUM_CHANNELS-1:0] CHANNEL_SYNC,
    output reg [`NUM_CHANNELS-1:0] CHANNEL_CONNECTED,
    output wire [`NUM_USERS-1:0] USER_EVENT_ASYNC,
    output wire [`NUM_USERS-1:0] USER_EVENT_SYNC,
    output wire [`NUM_PORT_OUTPUTS-1:0] PORT_EVENT_OUTPUT
);
    reg [`NUM_CHANNELS*`GEN_SEL_W-1:0] channel_generator_select_r;
    reg [`NUM_SELECTS*`USER_SEL_W-1:0] consumer_channel_select_r;
    reg [`PIT_CNT_W-1:0] pit_cnt_r;
    wire [`NUM_PIT_TAPS-1:0] pit_taps;
    wire [`NUM_CHANNELS-1:0] async_into_sync;
    wire [`NUM_CHANNELS-1:0] synced;
    wire [`NUM_CHANNELS-1:0] is_async;
    wire [`NUM_SELECTS-1:0] sel_async;
    wire [`NUM_SELECTS-1:0] sel_sync;

    // Picks one generator; bit 1 marks an asynchronous source, bit 0 is its level
    function [1:0] gen_pick;
        input [`GEN_SEL_W-1:0] sel;
        input [`NUM_PIT_TAPS-1:0] pit;
        input [`NUM_LUTS-1:0] lut;
        input comp;
        input [`NUM_PINS-1:0] pins;
        input [`NUM_SYNC_PULSES-1:0] pulses;
        input baud;
        input sck;
        reg [`GEN_SEL_W-1:0] off;
        begin
            gen_pick = 2'h0;
            off = 8'h00;
            if (sel >= `GEN_PIT_BASE && sel < `GEN_PIT_BASE + `NUM_PIT_TAPS) begin
                off = sel - `GEN_PIT_BASE;
                gen_pick = {1'b1, pit[`NUM_PIT_TAPS-1-off[2:0]]};
            end else if (sel >= `GEN_LUT_BASE && sel < `GEN_LUT_BASE + `NUM_LUTS) begin
                off = sel - `GEN_LUT_BASE;
                gen_pick = {1'b1, lut[off[1:0]]};
            end else if (sel == `GEN_COMPARATOR) begin
                gen_pick = {1'b1, comp};
            end else if (sel >= `GEN_PIN_BASE && sel < `GEN_PIN_BASE + `NUM_PINS) begin
                off = sel - `GEN_PIN_BASE;
                gen_pick = {1'b1, pins[off[2:0]]};
            end else if (sel >= `GEN_PULSE_BASE && sel < `GEN_PULSE_BASE + `NUM_SYNC_PULSES) begin
                off = sel - `GEN_PULSE_BASE;
                gen_pick = {1'b0, pulses[off[2:0]]};
            end else if (sel == `GEN_BAUD_CLOCK) begin
                gen_pick = {1'b0, baud};
            end else if (sel == `GEN_SPI_CLOCK) begin
                gen_pick = {1'b0, sck};
            end
        end
    endfunction

    // Consumer mux: code 0 listens to nothing, codes 1..6 pick a channel
    function user_pick;
        input [`USER_SEL_W-1:0] sel;
        input [`NUM_CHANNELS-1:0] chans;
        begin
            user_pick = 1'b0;
            if (sel != 3'h0 && sel <= `NUM_CHANNELS) begin
                user_pick = chans[sel - 3'h1];
            end
        end
    endfunction

    // Periodic taps: bit k of the tick counter has period 2^(k+1) ticks
    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pit_cnt_r <= {`PIT_CNT_W{1'b0}};
        end else if (RTC_PRESCALED_TICK) begin
            pit_cnt_r <= pit_cnt_r + 13'h0001;
        end
    end
    // Index 7 is periodic_tap_div_max (8192), index 0 is periodic_tap_div_min (64)
    assign pit_taps = pit_cnt_r[`PIT_CNT_W-1:`PIT_TAP_LSB];

    // Selection storage, cleared at reset so nothing is connected
    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            channel_generator_select_r <= {`NUM_CHANNELS{`GEN_SEL_RESET}};
            consumer_channel_select_r <= {`NUM_SELECTS{`USER_SEL_RESET}};
        end else begin
            if (CHAN_SEL_WR && CHAN_SEL_ADDR < `NUM_CHANNELS) begin
                channel_generator_select_r[CHAN_SEL_ADDR*`GEN_SEL_W +: `GEN_SEL_W] <= CHAN_SEL_DATA;
            end
            if (USER_SEL_WR && USER_SEL_ADDR < `NUM_SELECTS) begin
                consumer_channel_select_r[USER_SEL_ADDR*`USER_SEL_W +: `USER_SEL_W] <= USER_SEL_DATA;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1) begin : g_chan
            wire [1:0] pick;
            assign pick = gen_pick(channel_generator_select_r[ch*`GEN_SEL_W +: `GEN_SEL_W],
                pit_taps, LOGIC_TABLE_OUTPUT, ANALOG_COMPARATOR, PORT_PIN_LEVEL,
                SYNC_PULSE_EVENT, SERIAL_BAUD_CLOCK_EVENT, SPI_HOST_CLOCK_EVENT);
            assign is_async[ch] = pick[1];
            assign CHANNEL_ASYNC[ch] = pick[0];
            assign async_into_sync[ch] = pick[1] & pick[0];
            event_sync u_sync (
                .CORE_CLK(CORE_CLK),
                .SYS_RST(SYS_RST),
                .ev_in(async_into_sync[ch]),
                .ev_out(synced[ch])
            );
            // Sync sources pass straight; async ones only through the synchronizer
            assign CHANNEL_SYNC[ch] = is_async[ch] ? synced[ch] : pick[0];
        end
    endgenerate

    // Connection status for observation
    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CHANNEL_CONNECTED <= {`NUM_CHANNELS{1'b0}};
        end else begin
            CHANNEL_CONNECTED <= connected_nxt(channel_generator_select_r);
        end
    end

    function [`NUM_CHANNELS-1:0] connected_nxt;
        input [`NUM_CHANNELS*`GEN_SEL_W-1:0] sels;
        integer k;
        begin
            connected_nxt = {`NUM_CHANNELS{1'b0}};
            for (k = 0; k < `NUM_CHANNELS; k = k + 1) begin
                connected_nxt[k] = (sels[k*`GEN_SEL_W +: `GEN_SEL_W] != `GEN_NONE);
            end
        end
    endfunction

    genvar u;
    generate
        for (u = 0; u < `NUM_SELECTS; u = u + 1) begin : g_user
            assign sel_async[u] = user_pick(consumer_channel_select_r[u*`USER_SEL_W +: `USER_SEL_W],
                CHANNEL_ASYNC);
            assign sel_sync[u] = user_pick(consumer_channel_select_r[u*`USER_SEL_W +: `USER_SEL_W],
                CHANNEL_SYNC);
        end
    endgenerate

    assign USER_EVENT_ASYNC = sel_async[`NUM_USERS-1:0];
    assign USER_EVENT_SYNC = sel_sync[`NUM_USERS-1:0];
    // Port outputs are consumers 8..10 that use the async subchannel directly
    assign PORT_EVENT_OUTPUT = sel_async[`NUM_SELECTS-1:`NUM_USERS];
endmodule // event_router

// file: event_router_properties.sv
// Port checker for the event router
`timescale 1ns/1ps
module event_router_properties (
    input wire CORE_CLK,
    input wire SYS_RST,
    input wire CHAN_SEL_WR,
    input wire [2:0] CHAN_SEL_ADDR,
    input wire [7:0] CHAN_SEL_DATA,
    input wire USER_SEL_WR,
    input wire [3:0] USER_SEL_ADDR,
    input wire [2:0] USER_SEL_DATA,
    input wire [7:0] PORT_PIN_LEVEL,
    input wire [7:0] SYNC_PULSE_EVENT,
    input wire [5:0] CHANNEL_ASYNC,
    input wire [5:0] CHANNEL_SYNC,
    input wire [5:0] CHANNEL_CONNECTED,
    input wire [7:0] USER_EVENT_ASYNC,
    input wire [7:0] USER_EVENT_SYNC,
    input wire [2:0] PORT_EVENT_OUTPUT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    reg [7:0] sel0_r;
    reg [7:0] sel1_r;
    reg [2:0] usr0_r;
    reg [2:0] prt0_r;
    // Shadow copies of the selects under watch
    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sel0_r <= 8'h00;
            sel1_r <= 8'h00;
            usr0_r <= 3'h0;
            prt0_r <= 3'h0;
        end else begin
            if (CHAN_SEL_WR && CHAN_SEL_ADDR == 3'h0) sel0_r <= CHAN_SEL_DATA;
            if (CHAN_SEL_WR && CHAN_SEL_ADDR == 3'h1) sel1_r <= CHAN_SEL_DATA;
            if (USER_SEL_WR && USER_SEL_ADDR == 4'h0) usr0_r <= USER_SEL_DATA;
            if (USER_SEL_WR && USER_SEL_ADDR == 4'h8) prt0_r <= USER_SEL_DATA;
        end
    end
    chk_reset_no_link: assert property ($fell(SYS_RST) |-> CHANNEL_CONNECTED == 6'h00)
        else $error("channel linked after reset");
    chk_connect_flag: assert property (CHAN_SEL_WR && CHAN_SEL_ADDR == 3'h0 ##1 !CHAN_SEL_WR [*2]
        |-> CHANNEL_CONNECTED[0] == (sel0_r != 8'h00)) else $error("connected flag wrong");
    chk_async_pass: assert property (sel0_r == 8'h40 |-> CHANNEL_ASYNC[0] == PORT_PIN_LEVEL[0])
        else $error("async path not direct");
    chk_sync_lag: assert property (sel0_r == 8'h40 && $past(sel0_r, 3) == 8'h40
        |-> CHANNEL_SYNC[0] == $past(PORT_PIN_LEVEL[0], 2)) else $error("sync lag wrong");
    chk_sync_direct: assert property (sel1_r == 8'h30 |-> CHANNEL_SYNC[1] == SYNC_PULSE_EVENT[0]
        && CHANNEL_ASYNC[1] == SYNC_PULSE_EVENT[0]) else $error("sync source delayed");
    chk_user_pick: assert property (usr0_r == 3'h1 |-> USER_EVENT_ASYNC[0] == CHANNEL_ASYNC[0]
        && USER_EVENT_SYNC[0] == CHANNEL_SYNC[0]) else $error("user mux wrong");
    chk_pin_forward: assert property (prt0_r == 3'h1 |-> PORT_EVENT_OUTPUT[0] == CHANNEL_ASYNC[0])
        else $error("port output wrong");
    chk_idle_quiet: assert property (sel0_r == 8'h00 |-> !CHANNEL_ASYNC[0])
        else $error("idle channel active");
endmodule // event_router_properties
bind event_router event_router_properties chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CHAN_SEL_WR(CHAN_SEL_WR),
    .CHAN_SEL_ADDR(CHAN_SEL_ADDR), .CHAN_SEL_DATA(CHAN_SEL_DATA), .USER_SEL_WR(USER_SEL_WR),
    .USER_SEL_ADDR(USER_SEL_ADDR), .USER_SEL_DATA(USER_SEL_DATA), .PORT_PIN_LEVEL(PORT_PIN_LEVEL),
    .SYNC_PULSE_EVENT(SYNC_PULSE_EVENT), .CHANNEL_ASYNC(CHANNEL_ASYNC), .CHANNEL_SYNC(CHANNEL_SYNC),
    .CHANNEL_CONNECTED(CHANNEL_CONNECTED), .USER_EVENT_ASYNC(USER_EVENT_ASYNC),
    .USER_EVENT_SYNC(USER_EVENT_SYNC), .PORT_EVENT_OUTPUT(PORT_EVENT_OUTPUT));

// file: event_router_regs.vh
// Constants for the event router: sizes, selection codes and reset values
`ifndef EVENT_ROUTER_REGS_VH
`define EVENT_ROUTER_REGS_VH
`define NUM_CHANNELS 6
`define NUM_USERS 8
`define NUM_PORT_OUTPUTS 3
`define NUM_SELECTS 11
`define GEN_SEL_W 8
`define USER_SEL_W 3
`define USER_ADDR_W 4
`define CHAN_ADDR_W 3
`define NUM_PIT_TAPS 8
`define NUM_LUTS 4
`define NUM_PINS 8
`define NUM_SYNC_PULSES 8
`define PIT_CNT_W 13
`define PIT_TAP_LSB 5
`define SYNC_STAGES 2
`define GEN_SEL_RESET 8'h00
`define USER_SEL_RESET 3'h0
`define GEN_NONE 8'h00
`define GEN_PIT_BASE 8'h01
`define GEN_LUT_BASE 8'h10
`define GEN_COMPARATOR 8'h20
`define GEN_PULSE_BASE 8'h30
`define GEN_BAUD_CLOCK 8'h38
`define GEN_SPI_CLOCK 8'h39
`define GEN_PIN_BASE 8'h40
`endif

// file: event_router_test.sv
// Self-checking bench for the event router
`timescale 1ns/1ps
module event_router_test;
    reg clk = 1'b0, rst = 1'b1, cw = 1'b0, uw = 1'b0, comp = 1'b1, fire = 1'b0;
    reg [2:0] ca = 3'h0, ud = 3'h0;
    reg [3:0] ua = 4'h0, lut = 4'hf;
    reg [7:0] cd = 8'h00, pins = 8'hff;
    wire [7:0] pulse, ue_a, ue_s;
    wire baud, tick;
    wire [5:0] ch_a, ch_s, conn;
    wire [2:0] pe;
    integer miscompares = 0, samples_checked = 0, i;
    initial forever #25 clk = ~clk;
    event_sources far (.clk(clk), .fire(fire), .pulse(pulse), .baud(baud), .tick(tick));
    event_router dut (.CORE_CLK(clk), .SYS_RST(rst), .CHAN_SEL_WR(cw), .CHAN_SEL_ADDR(ca), .CHAN_SEL_DATA(cd),
        .USER_SEL_WR(uw), .USER_SEL_ADDR(ua), .USER_SEL_DATA(ud), .RTC_PRESCALED_TICK(tick),
        .LOGIC_TABLE_OUTPUT(lut), .ANALOG_COMPARATOR(comp), .PORT_PIN_LEVEL(pins), .SYNC_PULSE_EVENT(pulse),
        .SERIAL_BAUD_CLOCK_EVENT(baud), .SPI_HOST_CLOCK_EVENT(baud), .CHANNEL_ASYNC(ch_a), .CHANNEL_SYNC(ch_s),
        .CHANNEL_CONNECTED(conn), .USER_EVENT_ASYNC(ue_a), .USER_EVENT_SYNC(ue_s), .PORT_EVENT_OUTPUT(pe));
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_sim;
        if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wr(input logic chan, input [3:0] a, input [7:0] d);
        @(negedge clk);
        if (chan) begin cw <= 1'b1; ca <= a[2:0]; cd <= d; end
        else begin uw <= 1'b1; ua <= a; ud <= d[2:0]; end
        @(negedge clk);
        cw <= 1'b0;
        uw <= 1'b0;
    endtask
    task wait_tap(input logic v);
        for (i = 0; i < 300 && ch_a[4] !== v; i = i + 1) @(negedge clk);
        check("tap", {7'h00, ch_a[4]}, {7'h00, v});
        if (ch_a[4] !== v) end_sim;
    endtask
    task t_reset;
        @(negedge clk);
        check("idle", {2'h0, conn | ch_a}, 8'h00);
        check("idle out", ue_a | {5'h00, pe}, 8'h00);
    endtask
    task t_pin;
        wr(1'b1, 4'h0, 8'h40);
        wr(1'b0, 4'h0, 8'h01);
        wr(1'b0, 4'h8, 8'h01);
        check("conn", {2'h0, conn}, 8'h01);
        pins <= 8'h00;
        repeat (3) @(negedge clk);
        pins <= 8'h01;
        #5 check("async", {ue_a[0], pe[0], ch_a[0], ch_s[0]}, 8'h0e);
        @(posedge clk) #1 check("sync1", {7'h00, ch_s[0]}, 8'h00);
        @(posedge clk) #1 check("sync2", {ue_s[0], ch_s[0]}, 8'h03);
    endtask
    task t_pulse;
        wr(1'b1, 4'h1, 8'h30);
        fire <= 1'b1;
        @(negedge clk) fire <= 1'b0;
        #5 check("pulse", {ch_a[1], ch_s[1]}, 8'h03);
        @(negedge clk) #5 check("pulse end", {ch_a[1], ch_s[1]}, 8'h00);
        wr(1'b1, 4'h1, 8'h38);
        repeat (4) @(negedge clk) #5 check("baud", {ch_a[1], ch_s[1]}, {baud, baud});
    endtask
    task t_parallel;
        wr(1'b1, 4'h2, 8'h20);
        wr(1'b1, 4'h3, 8'h13);
        wr(1'b1, 4'h5, 8'h47);
        wr(1'b1, 4'h4, 8'h08);
        lut <= 4'h7;
        pins <= 8'h81;
        @(negedge clk) #5 check("parallel", {2'h0, ch_a & 6'h2f}, 8'h25);
        check("all conn", {2'h0, conn}, 8'h3f);
        wait_tap(1'b0);
        wait_tap(1'b1);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst <= 1'b0;
        t_reset;
        t_pin;
        t_pulse;
        t_parallel;
        end_sim;
    end
endmodule // event_router_test

// file: event_sources.sv
// Model of the generating peripherals on the core clock
`timescale 1ns/1ps
module event_sources (
    input wire clk,
    input wire fire,
    output reg [7:0] pulse,
    output reg baud,
    output reg tick
);
    reg [1:0] div_r = 2'h0;
    initial pulse = 8'h00;
    initial baud = 1'b0;
    initial tick = 1'b0;
    always @(negedge clk) begin
        pulse <= {7'h00, fire};
        div_r <= div_r + 2'h1;
        baud <= div_r[1];
        tick <= ~tick;
    end
endmodule // event_sources

// file: event_sync.v
// Two-stage synchronizer that moves an asynchronous event onto the core clock
`timescale 1ns/1ps
`include "event_router_regs.vh"
module event_sync (
    input wire CORE_CLK,
    input wire SYS_RST,
    input wire ev_in,
    output wire ev_out
);
    reg [`SYNC_STAGES-1:0] stage_r;
    // First stage only feeds the second; output is the last stage
    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            stage_r <= {`SYNC_STAGES{1'b0}};
        end else begin
            stage_r <= {stage_r[`SYNC_STAGES-2:0], ev_in};
        end
    end
    assign ev_out = stage_r[`SYNC_STAGES-1];
endmodule // event_sync
